// ---- hw/phy_mgmt_pkg.sv ----
// shared constants, field positions and carrier structs of the management register bank
package phy_mgmt_pkg;
  // ----------------------------------------
  // register indices
  // ----------------------------------------
  localparam logic [4:0] REG_CONTROL   = 5'h00; // basic_control
  localparam logic [4:0] REG_STATUS    = 5'h01; // basic_status
  localparam logic [4:0] REG_ID_HIGH   = 5'h02; // identifier_high
  localparam logic [4:0] REG_ID_LOW    = 5'h03; // identifier_low
  localparam logic [4:0] REG_ADVERTISE = 5'h04; // negotiation_advertise
  localparam logic [4:0] REG_PARTNER   = 5'h05; // partner_ability
  localparam logic [4:0] REG_EXPANSION = 5'h06; // negotiation_expansion
  localparam logic [4:0] REG_MMD_CTRL  = 5'h0d; // indirect access control
  localparam logic [4:0] REG_MMD_DATA  = 5'h0e; // indirect address/data
  localparam logic [4:0] REG_FUNC_CTRL = 5'h1c; // vendor function control
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTL_RESET    = 15;
  localparam int CTL_LOOP     = 14;
  localparam int CTL_SPEED    = 13;
  localparam int CTL_ANEN     = 12;
  localparam int CTL_PDOWN    = 11;
  localparam int CTL_ISOLATE  = 10;
  localparam int CTL_RESTART  = 9;
  localparam int CTL_DUPLEX   = 8;
  localparam int CTL_COLTEST  = 7;
  localparam int STS_NOPRE    = 6;
  localparam int FUNC_LOOP    = 1;  // loopback enable in function control
  // ----------------------------------------
  // reset values and masks
  // ----------------------------------------
  localparam logic [15:0] STS_CONST     = 16'h7809; // fixed capability bits
  localparam logic [15:0] ADV_RESET     = 16'h81e1; // next page, 4 rates, selector 00001
  localparam logic [15:0] ADV_WMASK     = 16'hadff; // writable advertisement bits
  localparam logic [15:0] PARTNER_RESET = 16'h0001; // selector only
  localparam logic [15:0] MMD_CTRL_MASK = 16'hc01f; // function and device number
  localparam logic [15:0] FUNC_RESET    = 16'h0000;
  localparam logic        SPEED_RESET   = 1'b1;     // no speed strap
  // ----------------------------------------
  // indirect space
  // ----------------------------------------
  localparam logic [4:0]  MMD_DEV_AFED = 5'h1b;
  localparam logic [15:0] MMD_REG_AFED = 16'h0000;
  localparam logic [4:0]  MMD_DEV_SQ   = 5'h1c;
  localparam logic [15:0] MMD_REG_SQ   = 16'h00ac;
  localparam logic [1:0]  MMD_FN_ADDR   = 2'h0; // address access
  localparam logic [1:0]  MMD_FN_DATA   = 2'h1; // data, no increment
  localparam logic [1:0]  MMD_FN_INC_RW = 2'h2; // data, increment on reads and writes
  localparam logic [1:0]  MMD_FN_INC_WR = 2'h3; // data, increment on writes only
  // ----------------------------------------
  // serial frame
  // ----------------------------------------
  localparam logic [5:0] PRE_ONES  = 6'h20; // 32 preamble ones
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [1:0] OP_WRITE  = 2'h1;
  localparam logic [4:0] HDR_LAST  = 5'h0c; // start bit 2, op, phy, reg
  localparam logic [4:0] RD_LAST   = 5'h10; // 16 data bits then release
  localparam logic [4:0] WR_LAST   = 5'h11; // turnaround plus 16 data bits
  localparam logic [2:0] STRAP_SETTLE = 3'h3; // cycles for straps through synchroniser
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic        link_up;
    logic        an_complete;
    logic        remote_fault;
    logic        jabber;
    logic        par_det_fault;
    logic        page_rx;
    logic        partner_an_able;
    logic        an_speed_100;
    logic        an_full_duplex;
    logic [15:0] partner_word;
    logic [15:0] signal_quality;
  } stat_s;
  typedef struct packed {
    logic        sw_reset;
    logic        an_restart;
    logic        core_enable;
    logic        loopback;
    logic        speed_100;
    logic        full_duplex;
    logic        an_enable;
    logic        isolate;
    logic        col_test;
    logic [15:0] afed_ctrl;
  } ctrl_s;
endpackage : phy_mgmt_pkg

// ---- hw/phy_mgmt_sync.sv ----
// two-flop synchroniser for pins entering the ref_clk domain
`timescale 1ns/1ps
module phy_mgmt_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  if (WIDTH < 1) begin : g_bad_width
    $error("phy_mgmt_sync needs at least one bit");
  end
  logic [WIDTH-1:0] meta; // first stage, read only by q
  // ----------------------------------------
  // two stages
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : phy_mgmt_sync

// ---- hw/phy_mgmt_regs.sv ----
// management register bank with serial management frame engine
`timescale 1ns/1ps
module phy_mgmt_regs #(
  parameter logic [15:0] ID_HIGH  = 16'h5a3c, // arbitrary organisation bits
  parameter logic [5:0]  ID_TAIL  = 6'h2d,    // arbitrary organisation bits
  parameter logic [5:0]  MODEL    = 6'h13,    // arbitrary model number
  parameter logic [3:0]  REVISION = 4'h2      // arbitrary revision
) (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          mdc,
  input  wire logic          mdio_in,
  output logic               mdio_out,
  output logic               mdio_oe,
  input  wire logic [4:0]    phy_addr_strap,
  input  wire logic          negotiation_strap,
  input  wire logic          duplex_strap,
  input  phy_mgmt_pkg::stat_s core_stat,
  output phy_mgmt_pkg::ctrl_s core_ctrl
);
  // ----------------------------------------
  // types and helpers
  // ----------------------------------------
  typedef enum logic [2:0] {ST_PRE, ST_HDR, ST_TA, ST_READ, ST_WRITE, ST_SKIP} frame_e;

  // merge writable bits of a new word into an old one
  function automatic logic [15:0] merge(input logic [15:0] old_w, input logic [15:0] new_w,
                                        input logic [15:0] mask);
    merge = (old_w & ~mask) | (new_w & mask);
  endfunction : merge

  // ----------------------------------------
  // pin synchronisation
  // ----------------------------------------
  logic [8:0] pins_s;    // synchronised pins
  logic       mdc_q;     // previous synced mdc
  phy_mgmt_sync #(.WIDTH(9)) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       ({mdc, mdio_in, phy_addr_strap, negotiation_strap, duplex_strap}),
    .q       (pins_s)
  );
  wire       mdc_s   = pins_s[8];
  wire       bit_in  = pins_s[7];
  wire [4:0] addr_s  = pins_s[6:2];
  wire       neg_s   = pins_s[1];
  wire       dup_s   = pins_s[0];
  wire       rise    = mdc_s & ~mdc_q; // link clock rising edge

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic        loop_q, speed_q, anen_q, pdown_q, iso_q, dup_q, col_q;
  logic        sw_q, restart_q;        // one-cycle pulses
  logic [2:0]  strap_cnt;              // strap settle countdown
  logic [4:0]  phy_addr;               // latched address strap
  logic        nopre_q;                // preamble suppression
  logic        link_q, rf_q, jab_q;    // status latches
  logic        pdf_q, page_q;          // expansion latches
  logic [15:0] adv_q, partner_q, func_q, afed_q;
  logic [15:0] mmd_ctl;                // function and device number
  logic [15:0] mmd_addr [2];           // per-device address registers

  // ----------------------------------------
  // frame engine state
  // ----------------------------------------
  frame_e      state, next_state;
  logic [4:0]  cnt, next_cnt;
  logic [5:0]  pre_cnt;                // consecutive ones seen
  logic [12:0] hdr;
  logic [15:0] wr_sh, rd_sh;
  logic [4:0]  acc_reg;                // register of a write frame
  logic        next_oe, next_out;
  logic [15:0] rd_word;                // word picked by the read multiplexer
  localparam logic [5:0] PRE_ONES_W  = phy_mgmt_pkg::PRE_ONES;
  localparam int         CTL_RESET_I = phy_mgmt_pkg::CTL_RESET;
  localparam int         FUNC_LOOP_I = phy_mgmt_pkg::FUNC_LOOP;

  wire [12:0] hdr_next  = {hdr[11:0], bit_in};
  wire [15:0] wr_next   = {wr_sh[14:0], bit_in};
  wire [1:0]  op        = hdr_next[11:10];
  wire [4:0]  rd_addr   = hdr_next[4:0];
  wire        pre_ok    = (pre_cnt == PRE_ONES_W) | nopre_q;
  wire        hdr_done  = rise & (state == ST_HDR) & (cnt == phy_mgmt_pkg::HDR_LAST);
  wire        for_us    = hdr_next[12] & (hdr_next[9:5] == phy_addr);
  wire        rd_go     = hdr_done & for_us & (op == phy_mgmt_pkg::OP_READ);
  wire        wr_go     = rise & (state == ST_WRITE) & (cnt == phy_mgmt_pkg::WR_LAST);

  // ----------------------------------------
  // frame sequencing
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_oe    = mdio_oe;
    next_out   = mdio_out;
    if (rise) begin
      case (state)
        ST_PRE: begin
          if (!bit_in && pre_ok) begin // start bit zero after 32 idle ones, or at any time while preamble suppression is set
            next_state = ST_HDR;
            next_cnt   = '0;
          end
        end
        ST_HDR: begin
          next_cnt = cnt + 5'h01;
          if (cnt == phy_mgmt_pkg::HDR_LAST) begin
            next_cnt = '0;
            if (!hdr_next[12]) begin // bad start, resync
              next_state = ST_PRE;
            end else if (!for_us) begin // other address, ride it out
              next_state = ST_SKIP;
            end else if (op == phy_mgmt_pkg::OP_READ) begin
              next_state = ST_TA;
            end else if (op == phy_mgmt_pkg::OP_WRITE) begin
              next_state = ST_WRITE;
            end else begin
              next_state = ST_SKIP;
            end
          end
        end
        ST_TA: begin // drive the zero turnaround bit
          next_state = ST_READ;
          next_cnt   = '0;
          next_oe    = 1'b1;
          next_out   = 1'b0;
        end
        ST_READ: begin
          next_cnt = cnt + 5'h01;
          next_out = rd_sh[15];
          if (cnt == phy_mgmt_pkg::RD_LAST) begin // release after last bit
            next_state = ST_PRE;
            next_oe    = 1'b0;
            next_out   = 1'b0;
          end
        end
        ST_WRITE, ST_SKIP: begin
          next_cnt = cnt + 5'h01;
          if (cnt == phy_mgmt_pkg::WR_LAST) begin
            next_state = ST_PRE;
          end
        end
        default: begin
          next_state = ST_PRE;
          next_oe    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state    <= ST_PRE;
      cnt      <= '0;
      mdio_oe  <= 1'b0;
      mdio_out <= 1'b0;
      mdc_q    <= 1'b0;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      mdio_oe  <= next_oe;
      mdio_out <= next_out;
      mdc_q    <= mdc_s;
    end
  end

  // shifters and preamble counter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pre_cnt <= '0;
      hdr     <= '0;
      wr_sh   <= '0;
      rd_sh   <= '0;
      acc_reg <= '0;
    end else if (rise) begin
      pre_cnt <= !bit_in ? 6'h00 : (pre_ok ? pre_cnt : pre_cnt + 6'h01);
      hdr     <= hdr_next;
      wr_sh   <= wr_next;
      if (hdr_done) acc_reg <= rd_addr;
      if (rd_go) rd_sh <= rd_word;
      else if (state == ST_READ) rd_sh <= {rd_sh[14:0], 1'b0};
    end
  end

  // ----------------------------------------
  // indirect space decode
  // ----------------------------------------
  wire [1:0]  mmd_fn   = mmd_ctl[15:14];
  wire [4:0]  mmd_dev  = mmd_ctl[4:0];
  wire        dev_ok   = (mmd_dev == phy_mgmt_pkg::MMD_DEV_AFED) | (mmd_dev == phy_mgmt_pkg::MMD_DEV_SQ);
  wire        dev_idx  = (mmd_dev == phy_mgmt_pkg::MMD_DEV_SQ);
  wire [15:0] cur_addr = mmd_addr[dev_idx];
  wire        hit_afed = (mmd_dev == phy_mgmt_pkg::MMD_DEV_AFED) & (cur_addr == phy_mgmt_pkg::MMD_REG_AFED);
  wire        hit_sq   = (mmd_dev == phy_mgmt_pkg::MMD_DEV_SQ) & (cur_addr == phy_mgmt_pkg::MMD_REG_SQ);
  wire [15:0] mmd_rd   = hit_afed ? afed_q : (hit_sq ? core_stat.signal_quality : 16'h0000);
  wire [15:0] addr_rd  = dev_ok ? cur_addr : 16'h0000; // unknown devices read zero

  // ----------------------------------------
  // access strobes
  // ----------------------------------------
  wire ctl_wr    = wr_go & (acc_reg == phy_mgmt_pkg::REG_CONTROL);
  wire soft_rst  = ctl_wr & wr_next[CTL_RESET_I] & ~pdown_q;
  wire pd_exit   = ctl_wr & wr_next[CTL_RESET_I] & pdown_q;
  wire sts_rd    = rd_go & (rd_addr == phy_mgmt_pkg::REG_STATUS);
  wire exp_rd    = rd_go & (rd_addr == phy_mgmt_pkg::REG_EXPANSION);
  wire data_rd   = rd_go & (rd_addr == phy_mgmt_pkg::REG_MMD_DATA) & (mmd_fn != phy_mgmt_pkg::MMD_FN_ADDR);
  wire data_wr   = wr_go & (acc_reg == phy_mgmt_pkg::REG_MMD_DATA) & (mmd_fn != phy_mgmt_pkg::MMD_FN_ADDR);
  wire addr_wr   = wr_go & (acc_reg == phy_mgmt_pkg::REG_MMD_DATA) & (mmd_fn == phy_mgmt_pkg::MMD_FN_ADDR);
  wire bump      = (data_wr & (mmd_fn[1])) | (data_rd & (mmd_fn == phy_mgmt_pkg::MMD_FN_INC_RW));

  // ----------------------------------------
  // read multiplexer
  // ----------------------------------------
  always_comb begin
    case (rd_addr)
      phy_mgmt_pkg::REG_CONTROL:   rd_word = {1'b0, loop_q, speed_q, anen_q, pdown_q, iso_q, 1'b0,
                                              dup_q, col_q, 7'h00};
      phy_mgmt_pkg::REG_STATUS:    rd_word = phy_mgmt_pkg::STS_CONST
                                             | {9'h000, nopre_q, core_stat.an_complete, rf_q, 1'b0,
                                                link_q, jab_q, 1'b0};
      phy_mgmt_pkg::REG_ID_HIGH:   rd_word = ID_HIGH;
      phy_mgmt_pkg::REG_ID_LOW:    rd_word = {ID_TAIL, MODEL, REVISION};
      phy_mgmt_pkg::REG_ADVERTISE: rd_word = adv_q;
      phy_mgmt_pkg::REG_PARTNER:   rd_word = partner_q;
      phy_mgmt_pkg::REG_EXPANSION: rd_word = {11'h000, pdf_q, partner_q[15], 1'b1, page_q,
                                              core_stat.partner_an_able};
      phy_mgmt_pkg::REG_MMD_CTRL:  rd_word = mmd_ctl;
      phy_mgmt_pkg::REG_MMD_DATA:  rd_word = (mmd_fn == phy_mgmt_pkg::MMD_FN_ADDR) ? addr_rd : mmd_rd;
      phy_mgmt_pkg::REG_FUNC_CTRL: rd_word = func_q;
      default:                     rd_word = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {loop_q, pdown_q, iso_q, col_q, sw_q, restart_q} <= '0;
      speed_q   <= phy_mgmt_pkg::SPEED_RESET;
      anen_q    <= 1'b0;
      dup_q     <= 1'b1;
      strap_cnt <= phy_mgmt_pkg::STRAP_SETTLE;
    end else begin
      sw_q      <= soft_rst;
      restart_q <= ctl_wr & wr_next[phy_mgmt_pkg::CTL_RESTART] & ~soft_rst & ~pd_exit;
      if (soft_rst) begin // defaults, straps taken again next cycle
        {loop_q, pdown_q, iso_q, col_q} <= '0;
        speed_q   <= phy_mgmt_pkg::SPEED_RESET;
        dup_q     <= 1'b1;
        strap_cnt <= 3'h1;
      end else if (strap_cnt != 3'h0) begin
        strap_cnt <= strap_cnt - 3'h1;
        if (strap_cnt == 3'h1) begin
          anen_q <= neg_s;
          dup_q  <= ~dup_s;
        end
      end else if (pd_exit) begin
        pdown_q <= 1'b0;
      end else if (ctl_wr) begin
        loop_q  <= wr_next[phy_mgmt_pkg::CTL_LOOP];
        speed_q <= wr_next[phy_mgmt_pkg::CTL_SPEED];
        anen_q  <= wr_next[phy_mgmt_pkg::CTL_ANEN];
        pdown_q <= wr_next[phy_mgmt_pkg::CTL_PDOWN];
        iso_q   <= wr_next[phy_mgmt_pkg::CTL_ISOLATE];
        dup_q   <= wr_next[phy_mgmt_pkg::CTL_DUPLEX];
        col_q   <= wr_next[phy_mgmt_pkg::CTL_COLTEST];
      end
    end
  end

  // address strap taken in the same cycle as the strap loads
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phy_addr <= '0;
    end else if (strap_cnt == 3'h1) begin
      phy_addr <= addr_s;
    end
  end

  // ----------------------------------------
  // status and expansion latches
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {link_q, rf_q, jab_q, pdf_q, page_q} <= '0;
      nopre_q <= 1'b1;
    end else if (soft_rst) begin
      {link_q, rf_q, jab_q, pdf_q, page_q} <= '0;
      nopre_q <= 1'b1;
    end else begin
      link_q <= sts_rd ? core_stat.link_up : (link_q & core_stat.link_up);
      rf_q   <= core_stat.remote_fault | (rf_q & ~sts_rd);
      jab_q  <= core_stat.jabber | (jab_q & ~sts_rd);
      pdf_q  <= core_stat.par_det_fault | (pdf_q & ~exp_rd);
      page_q <= core_stat.page_rx | (page_q & ~exp_rd);
      if (wr_go && acc_reg == phy_mgmt_pkg::REG_STATUS) nopre_q <= wr_next[phy_mgmt_pkg::STS_NOPRE];
    end
  end

  // ----------------------------------------
  // advertisement, partner, vendor and indirect
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      adv_q       <= phy_mgmt_pkg::ADV_RESET;
      partner_q   <= phy_mgmt_pkg::PARTNER_RESET;
      func_q      <= phy_mgmt_pkg::FUNC_RESET;
      mmd_ctl     <= '0;
      afed_q      <= '0;
      mmd_addr[0] <= '0;
      mmd_addr[1] <= '0;
    end else if (soft_rst) begin
      adv_q       <= phy_mgmt_pkg::ADV_RESET;
      partner_q   <= phy_mgmt_pkg::PARTNER_RESET;
      func_q      <= phy_mgmt_pkg::FUNC_RESET;
      mmd_ctl     <= '0;
      afed_q      <= '0;
      mmd_addr[0] <= '0;
      mmd_addr[1] <= '0;
    end else begin
      if (wr_go && acc_reg == phy_mgmt_pkg::REG_ADVERTISE) begin
        adv_q <= merge(adv_q, wr_next, phy_mgmt_pkg::ADV_WMASK);
      end
      if (core_stat.page_rx) partner_q <= core_stat.partner_word;
      if (wr_go && acc_reg == phy_mgmt_pkg::REG_FUNC_CTRL) func_q <= wr_next;
      if (wr_go && acc_reg == phy_mgmt_pkg::REG_MMD_CTRL) begin
        mmd_ctl <= merge(mmd_ctl, wr_next, phy_mgmt_pkg::MMD_CTRL_MASK);
      end
      if (data_wr && hit_afed) afed_q <= wr_next;
      if (addr_wr && dev_ok) begin
        mmd_addr[dev_idx] <= wr_next;
      end else if (bump && dev_ok) begin
        mmd_addr[dev_idx] <= cur_addr + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // outputs to the transceiver core
  // ----------------------------------------
  assign core_ctrl.sw_reset    = sw_q;
  assign core_ctrl.an_restart  = restart_q & ~pdown_q;
  assign core_ctrl.core_enable = ~pdown_q;
  assign core_ctrl.loopback    = loop_q & func_q[FUNC_LOOP_I] & ~pdown_q;
  assign core_ctrl.speed_100   = anen_q ? core_stat.an_speed_100 : speed_q;
  assign core_ctrl.full_duplex = anen_q ? core_stat.an_full_duplex : dup_q;
  assign core_ctrl.an_enable   = anen_q;
  assign core_ctrl.isolate     = iso_q;
  assign core_ctrl.col_test    = col_q & ~pdown_q;
  assign core_ctrl.afed_ctrl   = afed_q;
endmodule : phy_mgmt_regs

// ---- tb/phy_mgmt_regs_properties.sv ----
// port checker of the management register bank
`timescale 1ns/1ps
module phy_mgmt_regs_properties (
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire logic                mdc,
  input wire logic                mdio_out,
  input wire logic                mdio_oe,
  input wire phy_mgmt_pkg::stat_s core_stat,
  input wire phy_mgmt_pkg::ctrl_s core_ctrl
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  reset_quiet_a: assert property ($fell(rst) |-> !mdio_oe && !core_ctrl.sw_reset)
    else $error("pin or pulse active at reset release");
  turn_low_a: assert property ($rose(mdio_oe) |-> !mdio_out ##1 (mdio_oe && !mdio_out)[*8])
    else $error("turnaround bit not driven low");
  drive_on_mdc_a: assert property ($changed(mdio_oe) || $changed(mdio_out) |-> mdc)
    else $error("data pin moved away from clock high phase");
  idle_low_a: assert property (!mdio_oe |-> !mdio_out)
    else $error("data driven while released");
  reset_pulse_a: assert property (core_ctrl.sw_reset |=> !core_ctrl.sw_reset)
    else $error("soft reset pulse too long");
  restart_pulse_a: assert property (core_ctrl.an_restart |-> core_ctrl.core_enable ##1 !core_ctrl.an_restart)
    else $error("restart pulse wrong");
  power_gate_a: assert property (core_ctrl.loopback || core_ctrl.col_test |-> core_ctrl.core_enable)
    else $error("function active in power down");
  speed_pick_a: assert property ((core_ctrl.an_enable && $stable(core_stat.an_speed_100))[*3]
    |-> core_ctrl.speed_100 == core_stat.an_speed_100) else $error("speed not negotiated");
  duplex_pick_a: assert property ((core_ctrl.an_enable && $stable(core_stat.an_full_duplex))[*3]
    |-> core_ctrl.full_duplex == core_stat.an_full_duplex) else $error("duplex not negotiated");
endmodule : phy_mgmt_regs_properties
bind phy_mgmt_regs phy_mgmt_regs_properties chk (.ref_clk(ref_clk), .rst(rst), .mdc(mdc),
  .mdio_out(mdio_out), .mdio_oe(mdio_oe), .core_stat(core_stat), .core_ctrl(core_ctrl));

// ---- tb/mdio_master.sv ----
// station management controller model, clock stands still between frames
`timescale 1ns/1ps
module mdio_master (
  output logic      mdc,
  output logic      mdio_drv,
  input  wire logic mdio
);
  initial begin
    mdc = 1'b0;
    mdio_drv = 1'b1;
  end
  // one frame with full preamble, fields msb first
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] v;
    v = {32'hffffffff, 2'b01, op, phy, rg, (op == 2'h1) ? {2'b10, wd} : 18'h3ffff};
    rd = 16'h0;
    for (int i = 0; i < 64; i++) begin
      mdio_drv = v[63-i]; // released bits read as pull-up
      #62.5 mdc = 1'b1;
      if (i >= 48) rd = {rd[14:0], mdio};
      #62.5 mdc = 1'b0;
    end
    mdio_drv = 1'b1;
  endtask : frame
endmodule : mdio_master

// ---- tb/phy_mgmt_regs_tb.sv ----
// self-checking bench of the management register bank
`timescale 1ns/1ps
module phy_mgmt_regs_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic mdc, mdio_drv, mdio_out, mdio_oe;
  wire  mdio = mdio_drv & (mdio_oe ? mdio_out : 1'b1); // open drain, pull-up
  phy_mgmt_pkg::stat_s core_stat = '0;
  phy_mgmt_pkg::ctrl_s core_ctrl;
  int num_errors = 0;
  int tests_run = 0;
  int restarts = 0;
  int resets = 0;
  logic neg_strap = 1'b1;
  logic dup_strap = 1'b0;
  logic [15:0] rd;
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (core_ctrl.an_restart === 1'b1) restarts++;
  always @(posedge ref_clk) if (core_ctrl.sw_reset === 1'b1) resets++;
  wire [15:0] ctl_seen = {11'h000, core_ctrl.speed_100, core_ctrl.full_duplex, core_ctrl.an_enable,
                          core_ctrl.isolate, core_ctrl.col_test};
  mdio_master M (.mdc(mdc), .mdio_drv(mdio_drv), .mdio(mdio));
  phy_mgmt_regs DUT (.ref_clk(ref_clk), .rst(rst), .mdc(mdc), .mdio_in(mdio), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .phy_addr_strap(5'h05), .negotiation_strap(neg_strap), .duplex_strap(dup_strap),
    .core_stat(core_stat), .core_ctrl(core_ctrl));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [4:0] rg, input logic [15:0] d);
    M.frame(2'h1, 5'h05, rg, d, rd);
    repeat (8) @(posedge ref_clk);
  endtask : wr
  task automatic rdc(input logic [4:0] rg, input logic [15:0] exp);
    M.frame(2'h2, 5'h05, rg, 16'h0, rd);
    check($sformatf("reg %h", rg), rd, exp);
  endtask : rdc
  task automatic t_defaults;
    logic [15:0] exp [0:6] = '{16'h3100, 16'h7849, 16'h5a3c, 16'hb532, 16'h81e1, 16'h0001, 16'h0004};
    for (int i = 0; i < 7; i++) rdc(5'(i), exp[i]);
    rdc(5'h09, 16'h0);
  endtask : t_defaults
  task automatic t_adv;
    logic [15:0] w;
    for (int i = 0; i < 4; i++) begin
      w = 16'h21e1 | 16'(i << 10) | 16'(i << 14);
      wr(5'h04, w);
      rdc(5'h04, w & 16'hadff);
    end
  endtask : t_adv
  task automatic t_latch;
    @(posedge ref_clk) core_stat.jabber <= 1'b1;
    core_stat.remote_fault <= 1'b1;
    core_stat.link_up <= 1'b1;
    core_stat.an_complete <= 1'b1;
    core_stat.page_rx <= 1'b1;
    core_stat.par_det_fault <= 1'b1;
    core_stat.partner_an_able <= 1'b1;
    core_stat.partner_word <= 16'hc5e1;
    @(posedge ref_clk) core_stat.jabber <= 1'b0;
    core_stat.remote_fault <= 1'b0;
    core_stat.page_rx <= 1'b0;
    core_stat.par_det_fault <= 1'b0;
    rdc(5'h01, 16'h787b);
    rdc(5'h01, 16'h786d);
    rdc(5'h05, 16'hc5e1);
    rdc(5'h06, 16'h001f);
    rdc(5'h06, 16'h000d);
    wr(5'h01, 16'h0000);
    rdc(5'h01, 16'h782d);
  endtask : t_latch
  task automatic t_ctrl;
    wr(5'h1c, 16'h0002);
    wr(5'h00, 16'h5100);
    check("loopback", {15'h0, core_ctrl.loopback}, 16'h1);
    wr(5'h00, 16'h1300);
    check("restarts", restarts[15:0], 16'h1);
    rdc(5'h00, 16'h1100);
    wr(5'h00, 16'h1900);
    check("core on", {15'h0, core_ctrl.core_enable}, 16'h0);
    wr(5'h00, 16'h8000);
    check("core on", {15'h0, core_ctrl.core_enable}, 16'h1);
    check("soft resets", resets[15:0], 16'h0);
    rdc(5'h04, 16'hade1);
    wr(5'h00, 16'h8000);
    rdc(5'h04, 16'h81e1);
    check("soft resets", resets[15:0], 16'h1);
    rdc(5'h00, 16'h3100);
  endtask : t_ctrl
  task automatic t_mmd;
    @(posedge ref_clk) core_stat.signal_quality <= 16'h5a5a;
    wr(5'h0d, 16'h001b);
    wr(5'h0e, 16'h0000);
    wr(5'h0d, 16'h401b);
    wr(5'h0e, 16'h1234);
    check("afed", core_ctrl.afed_ctrl, 16'h1234);
    wr(5'h0d, 16'h801b);
    rdc(5'h0e, 16'h1234);
    wr(5'h0d, 16'hc01b);
    rdc(5'h0e, 16'h0000);
    wr(5'h0d, 16'h001c);
    wr(5'h0e, 16'h00ac);
    wr(5'h0d, 16'h401c);
    rdc(5'h0e, 16'h5a5a);
    wr(5'h0d, 16'h0005);
    rdc(5'h0e, 16'h0000);
  endtask : t_mmd
  task automatic t_core;
    wr(5'h00, 16'h25ff);
    rdc(5'h00, 16'h2580);
    check("core ctrl", ctl_seen, 16'h001b);
    wr(5'h00, 16'h3100);
    check("core ctrl", ctl_seen, 16'h0004);
  endtask : t_core
  task automatic t_reset;
    @(posedge ref_clk) rst <= 1'b1;
    neg_strap <= 1'b0;
    dup_strap <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rdc(5'h00, 16'h2000);
  endtask : t_reset
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    t_defaults;
    t_adv;
    t_latch;
    t_ctrl;
    t_mmd;
    t_core;
    t_reset;
    stop_test;
  end
  initial begin
    #600_000;
    num_errors++;
    stop_test;
  end
endmodule : phy_mgmt_regs_tb
